// File: rtl/wkup_pkg.sv
// constants and types for the wake-up frame pattern register bank
package wkup_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int NUM_REGS = 13;
    localparam logic [7:0] OFF_P1_MASK2 = 8'h48;
    localparam logic [7:0] OFF_P1_MASK3 = 8'h4A;
    localparam logic [7:0] OFF_P2_CRC_LO = 8'h50;
    localparam logic [7:0] OFF_P2_CRC_HI = 8'h52;
    localparam logic [7:0] OFF_P2_MASK0 = 8'h54;
    localparam logic [7:0] OFF_P2_MASK1 = 8'h56;
    localparam logic [7:0] OFF_P2_MASK2 = 8'h58;
    localparam logic [7:0] OFF_P2_MASK3 = 8'h5A;
    localparam logic [7:0] OFF_P3_CRC_LO = 8'h60;
    localparam logic [7:0] OFF_P3_CRC_HI = 8'h62;
    localparam logic [7:0] OFF_P3_MASK0 = 8'h64;
    localparam logic [7:0] OFF_P3_MASK1 = 8'h66;
    localparam logic [7:0] OFF_P3_MASK2 = 8'h68;
    // storage slots
    localparam logic [3:0] IDX_P1_MASK2 = 4'h0;
    localparam logic [3:0] IDX_P1_MASK3 = 4'h1;
    localparam logic [3:0] IDX_P2_CRC_LO = 4'h2;
    localparam logic [3:0] IDX_P2_CRC_HI = 4'h3;
    localparam logic [3:0] IDX_P2_MASK0 = 4'h4;
    localparam logic [3:0] IDX_P2_MASK1 = 4'h5;
    localparam logic [3:0] IDX_P2_MASK2 = 4'h6;
    localparam logic [3:0] IDX_P2_MASK3 = 4'h7;
    localparam logic [3:0] IDX_P3_CRC_LO = 4'h8;
    localparam logic [3:0] IDX_P3_CRC_HI = 4'h9;
    localparam logic [3:0] IDX_P3_MASK0 = 4'hA;
    localparam logic [3:0] IDX_P3_MASK1 = 4'hB;
    localparam logic [3:0] IDX_P3_MASK2 = 4'hC;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] RD_NONE = 16'h0000;
    // ----------------------------------------------------------------
    // frame and crc
    // ----------------------------------------------------------------
    localparam logic [6:0] MASK_BYTES = 7'h40;
    localparam logic [6:0] POS_FIRST = 7'h00;
    localparam logic [6:0] POS_AFTER_SOF = 7'h01;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam int NUM_PAT = 2;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } rx_byte_t;
endpackage

// File: rtl/wkup_crc.sv
// byte-wise ethernet crc-32 accumulator for one pattern
`timescale 1ns/1ps
`default_nettype none
module wkup_crc
    import wkup_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    input wire logic restart,
    input wire logic take,
    input wire logic [7:0] data,
    output logic [31:0] crc_nxt
);
    logic [31:0] crc_r;
    logic [31:0] base;

    // reflected form, lsb of each byte first as on the wire
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // next value
    // ----------------------------------------------------------------
    always_comb begin
        base = restart ? CRC_INIT : crc_r;
        crc_nxt = take ? crc_byte(base, data) : base; // [R5]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= CRC_INIT;
        end else if (step) begin
            crc_r <= crc_nxt;
        end
    end
endmodule
`default_nettype wire

// File: rtl/wkup_pattern_regs.sv
// wake-up frame pattern registers and masked crc pattern detection
// Functional notes
// (R1) first mask word bit 0..15 selects frame bytes 1..16 in order
// (R2) second mask word bits 0..15 select frame bytes 17..32
// (R3) third mask word bits 0..15 select frame bytes 33..48
// (R4) fourth mask word selects bytes 49..64; later bytes never enter the crc
// (R5) crc is ethernet crc-32 over only the masked bytes
// (R6) crc low register holds expected crc bits 15..0
// (R7) crc high register holds bits 31..16; full word compared to computed crc
// (R8) every crc and mask register is 16-bit read-write, reset to zero; pattern 3 fourth mask word comes from PATTERN3_MASK_WORD3 input instead
// (R9) gaps between register groups hold nothing and read zero
// (R10) a pattern detects only while its enable is set
// (R11) masked crc equal to expected crc on an enabled pattern flags detection; the code also requires a nonzero mask, so an all-zero mask never flags
`timescale 1ns/1ps
`default_nettype none
module wkup_pattern_regs
    import wkup_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire reg_req_t REG_REQ,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    input wire rx_byte_t RX_BYTE,
    input wire logic PATTERN2_DETECT_ENABLE,
    input wire logic PATTERN3_DETECT_ENABLE,
    input wire logic [15:0] PATTERN3_MASK_WORD3,
    output logic [31:0] PATTERN1_MASK_HIGH,
    output logic [NUM_PAT-1:0] WAKE_DETECT
);
    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [15:0] regs_r [NUM_REGS];
    logic [15:0] regs_nxt [NUM_REGS];
    logic [15:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [4:0] dec;

    // {hit, slot}; reserved gaps simply miss
    function automatic logic [4:0] decode(input logic [7:0] a);
        if (a[7:1] == OFF_P1_MASK2[7:1]) decode = {1'b1, IDX_P1_MASK2};
        else if (a[7:1] == OFF_P1_MASK3[7:1]) decode = {1'b1, IDX_P1_MASK3};
        else if (a[7:1] == OFF_P2_CRC_LO[7:1]) decode = {1'b1, IDX_P2_CRC_LO};
        else if (a[7:1] == OFF_P2_CRC_HI[7:1]) decode = {1'b1, IDX_P2_CRC_HI};
        else if (a[7:1] == OFF_P2_MASK0[7:1]) decode = {1'b1, IDX_P2_MASK0};
        else if (a[7:1] == OFF_P2_MASK1[7:1]) decode = {1'b1, IDX_P2_MASK1};
        else if (a[7:1] == OFF_P2_MASK2[7:1]) decode = {1'b1, IDX_P2_MASK2};
        else if (a[7:1] == OFF_P2_MASK3[7:1]) decode = {1'b1, IDX_P2_MASK3};
        else if (a[7:1] == OFF_P3_CRC_LO[7:1]) decode = {1'b1, IDX_P3_CRC_LO};
        else if (a[7:1] == OFF_P3_CRC_HI[7:1]) decode = {1'b1, IDX_P3_CRC_HI};
        else if (a[7:1] == OFF_P3_MASK0[7:1]) decode = {1'b1, IDX_P3_MASK0};
        else if (a[7:1] == OFF_P3_MASK1[7:1]) decode = {1'b1, IDX_P3_MASK1};
        else if (a[7:1] == OFF_P3_MASK2[7:1]) decode = {1'b1, IDX_P3_MASK2};
        else decode = 5'h00; // [R9]
    endfunction

    assign dec = decode(REG_REQ.addr);

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (REG_REQ.wr && dec[4]) begin
            if (REG_REQ.be[0]) regs_nxt[dec[3:0]][7:0] = REG_REQ.wdata[7:0]; // [R8]
            if (REG_REQ.be[1]) regs_nxt[dec[3:0]][15:8] = REG_REQ.wdata[15:8]; // [R8]
        end
        rvalid_nxt = REG_REQ.rd;
        rdata_nxt = RD_NONE;
        if (REG_REQ.rd && dec[4]) begin
            rdata_nxt = regs_r[dec[3:0]]; // [R6] [R7]
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= REG_RESET; // [R8]
            end
            rdata_r <= RD_NONE;
            rvalid_r <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ----------------------------------------------------------------
    // frame position
    // ----------------------------------------------------------------
    logic [6:0] pos_r, pos_nxt;
    logic in_frame_r, in_frame_nxt;
    logic [6:0] idx;
    logic in_rng;

    always_comb begin
        idx = RX_BYTE.sof ? POS_FIRST : pos_r;
        in_rng = idx < MASK_BYTES; // [R4]
        pos_nxt = pos_r;
        in_frame_nxt = in_frame_r;
        if (RX_BYTE.valid) begin
            // saturate at 64 so long frames cannot wrap into the mask again
            if (RX_BYTE.sof) pos_nxt = POS_AFTER_SOF;
            else if (in_rng) pos_nxt = pos_r + POS_AFTER_SOF;
            in_frame_nxt = (in_frame_r || RX_BYTE.sof) && !RX_BYTE.eof;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pos_r <= POS_FIRST;
            in_frame_r <= 1'b0;
        end else begin
            pos_r <= pos_nxt;
            in_frame_r <= in_frame_nxt;
        end
    end

    // ----------------------------------------------------------------
    // per-pattern crc and compare
    // ----------------------------------------------------------------
    logic [63:0] mask64 [NUM_PAT];
    logic [31:0] expct [NUM_PAT];
    logic [31:0] crc_nxt [NUM_PAT];
    logic [NUM_PAT-1:0] en, take, match;
    logic [NUM_PAT-1:0] det_r, det_nxt;
    logic [31:0] p1_hi_r;

    always_comb begin
        // word n bit k is frame byte 16n+k+1
        mask64[0] = {regs_r[IDX_P2_MASK3], regs_r[IDX_P2_MASK2],
                     regs_r[IDX_P2_MASK1], regs_r[IDX_P2_MASK0]}; // [R1] [R2] [R3] [R4]
        mask64[1] = {PATTERN3_MASK_WORD3, regs_r[IDX_P3_MASK2],
                     regs_r[IDX_P3_MASK1], regs_r[IDX_P3_MASK0]}; // [R1] [R2] [R3] [R4]
        expct[0] = {regs_r[IDX_P2_CRC_HI], regs_r[IDX_P2_CRC_LO]}; // [R6] [R7]
        expct[1] = {regs_r[IDX_P3_CRC_HI], regs_r[IDX_P3_CRC_LO]}; // [R6] [R7]
        en = {PATTERN3_DETECT_ENABLE, PATTERN2_DETECT_ENABLE};
    end

    for (genvar g = 0; g < NUM_PAT; g++) begin : g_pat
        assign take[g] = RX_BYTE.valid && in_rng && mask64[g][idx[5:0]]; // [R5]
        // all-zero mask would match a zero expected crc; such a pattern never fires
        assign match[g] = (~crc_nxt[g] == expct[g]) && (|mask64[g]); // [R7]
        assign det_nxt[g] = RX_BYTE.valid && RX_BYTE.eof && (in_frame_r || RX_BYTE.sof)
                            && en[g] && match[g]; // [R10] [R11]
        wkup_crc u_crc (
            .clk(CLOCK),
            .rst_n(RST_N),
            .step(RX_BYTE.valid),
            .restart(RX_BYTE.sof),
            .take(take[g]),
            .data(RX_BYTE.data),
            .crc_nxt(crc_nxt[g])
        );
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            det_r <= '0;
            p1_hi_r <= {REG_RESET, REG_RESET};
        end else begin
            det_r <= det_nxt;
            p1_hi_r <= {regs_r[IDX_P1_MASK3], regs_r[IDX_P1_MASK2]};
        end
    end

    assign REG_RDATA = rdata_r;
    assign REG_RVALID = rvalid_r;
    assign WAKE_DETECT = det_r;
    assign PATTERN1_MASK_HIGH = p1_hi_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_rd_lo2;
        REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == OFF_P2_CRC_LO;
    endsequence
    sequence s_rd_gap;
        REG_REQ.rd && REG_REQ.addr == 8'h4C;
    endsequence

    property p_first_byte;
        RX_BYTE.valid && RX_BYTE.sof && regs_r[IDX_P2_MASK0][0] |-> take[0];
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("byte 1 not taken"); // [R1]
    property p_byte17;
        RX_BYTE.valid && !RX_BYTE.sof && pos_r == 7'h10 |-> take[0] == regs_r[IDX_P2_MASK1][0];
    endproperty
    a_byte17: assert property (p_byte17) else $error("byte 17 mapping wrong"); // [R2]
    property p_byte33;
        RX_BYTE.valid && !RX_BYTE.sof && pos_r == 7'h20 |-> take[1] == regs_r[IDX_P3_MASK2][0];
    endproperty
    a_byte33: assert property (p_byte33) else $error("byte 33 mapping wrong"); // [R3]
    property p_past64;
        RX_BYTE.valid && !RX_BYTE.sof && pos_r == MASK_BYTES |-> take == '0;
    endproperty
    a_past64: assert property (p_past64) else $error("byte after 64 taken"); // [R4]
    property p_skip;
        RX_BYTE.valid && !RX_BYTE.sof && !take[0] |-> crc_nxt[0] == g_pat[0].u_crc.crc_r;
    endproperty
    a_skip: assert property (p_skip) else $error("unmasked byte changed crc"); // [R5]
    property p_rd_lo;
        s_rd_lo2 |=> REG_RVALID && REG_RDATA == $past(regs_r[IDX_P2_CRC_LO]);
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("crc low readback wrong"); // [R6]
    property p_full_cmp;
        WAKE_DETECT[1] |-> $past(~crc_nxt[1]) == $past(expct[1]);
    endproperty
    a_full_cmp: assert property (p_full_cmp) else $error("detect without 32-bit match"); // [R7]
    property p_write;
        REG_REQ.wr && REG_REQ.be == 2'b11 && REG_REQ.addr == OFF_P3_MASK1
            |=> regs_r[IDX_P3_MASK1] == $past(REG_REQ.wdata) ##1 1'b1;
    endproperty
    a_write: assert property (p_write) else $error("mask write lost"); // [R8]
    property p_gap;
        s_rd_gap |=> REG_RVALID && REG_RDATA == RD_NONE;
    endproperty
    a_gap: assert property (p_gap) else $error("reserved gap read nonzero"); // [R9]
    property p_enable;
        WAKE_DETECT[0] |-> $past(PATTERN2_DETECT_ENABLE);
    endproperty
    a_enable: assert property (p_enable) else $error("detect while disabled"); // [R10]
    property p_fire;
        det_nxt[0] |=> WAKE_DETECT[0] ##1 !WAKE_DETECT[0] || $past(det_nxt[0]);
    endproperty
    a_fire: assert property (p_fire) else $error("detect pulse missing"); // [R11]
endmodule
`default_nettype wire

// File: tb/wkup_rx_source.sv
// receive-path frame source feeding the pattern detector
`timescale 1ns/1ps
`default_nettype none
module wkup_rx_source
    import wkup_pkg::*;
(
    input wire logic clk,
    output var rx_byte_t rx
);
    // ------------------------------------------------------------
    // frame bytes and sender
    // ------------------------------------------------------------
    logic [7:0] fr [0:79];
    initial rx = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: 8'hA5};
    // idle data toggles so a stale byte never passes for a real one
    task automatic send(input int len, input bit gaps);
        for (int i = 0; i < len; i++) begin
            if (gaps && i % 5 == 3) begin
                @(posedge clk);
                #1;
                rx = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~rx.data};
            end
            @(posedge clk);
            #1;
            rx = '{valid: 1'b1, sof: i == 0, eof: i == len - 1, data: fr[i]};
        end
        @(posedge clk);
        #1;
        rx = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~rx.data};
    endtask
endmodule
`default_nettype wire

// File: tb/wakeup_frame_pattern_regs_bench.sv
// self-checking bench for the wake-up pattern register bank
`timescale 1ns/1ps
`default_nettype none
module wakeup_frame_pattern_regs_bench;
    import wkup_pkg::*;
    // ------------------------------------------------------------
    // stimulus, watcher and checks
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t reg_req = '0;
    logic [15:0] rdata;
    logic rvalid;
    rx_byte_t rx;
    logic en2 = 1'b0;
    logic en3 = 1'b0;
    logic [15:0] p3m3 = 16'h0000;
    logic [31:0] p1_high;
    logic [1:0] wake;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 32'h8E3FD2B3;
    logic [15:0] rd_q[$];
    logic [1:0] wk_q[$];
    logic eof_d = 1'b0;
    logic [7:0] off [0:12] = '{8'h48, 8'h4A, 8'h50, 8'h52, 8'h54, 8'h56, 8'h58,
        8'h5A, 8'h60, 8'h62, 8'h64, 8'h66, 8'h68};
    logic [15:0] v [0:12];
    logic [63:0] m;
    logic [31:0] c;

    always #25 clock = ~clock;

    wkup_pattern_regs wkup_pattern_regs_inst (.CLOCK(clock), .RST_N(rst_n),
        .REG_REQ(reg_req), .REG_RDATA(rdata), .REG_RVALID(rvalid), .RX_BYTE(rx),
        .PATTERN2_DETECT_ENABLE(en2), .PATTERN3_DETECT_ENABLE(en3),
        .PATTERN3_MASK_WORD3(p3m3), .PATTERN1_MASK_HIGH(p1_high), .WAKE_DETECT(wake));
    wkup_rx_source wkup_rx_source_inst (.clk(clock), .rx(rx));

    task automatic test_done;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_wake(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] bsel = 2'h3);
        @(posedge clock);
        #1;
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: bsel, wdata: d};
        @(posedge clock);
        #1;
        reg_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        #1;
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'h0, wdata: 16'h0000};
        rd_q.push_back(e);
        @(posedge clock);
        #1;
        reg_req.rd = 1'b0;
    endtask
    // own reference: reflected crc-32, lsb first
    function automatic logic [31:0] crc_step(input logic [31:0] cr, input logic [7:0] d);
        logic [31:0] r;
        r = cr ^ {24'h0, d};
        for (int b = 0; b < 8; b++) r = r[0] ? (r >> 1) ^ CRC_POLY : r >> 1;
        return r;
    endfunction

    // a read answer with nothing queued compares against an impossible value
    always @(negedge clock) begin
        if (rvalid === 1'b1) begin
            chk_word({16'h0, rdata},
                rd_q.size() ? {16'h0, rd_q.pop_front()} : 32'hFFFFFFFF);
        end
        if (eof_d) begin
            chk_wake(wake, wk_q.size() ? wk_q.pop_front() : 2'h3);
        end else begin
            chk_wake(wake, 2'h0);
        end
        eof_d = (rx.valid === 1'b1) && (rx.eof === 1'b1);
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clock);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 13; i++) rd(off[i], 16'h0000);
        wr(8'h4C, 16'hFFFF);
        wr(8'h5E, 16'hFFFF);
        wr(8'h6C, 16'hFFFF);
        rd(8'h4C, 16'h0000);
        rd(8'h5E, 16'h0000);
        rd(8'h6C, 16'h0000);
        for (int i = 0; i < 13; i++) begin
            v[i] = 16'($random(seed));
            wr(off[i], v[i]);
        end
        for (int i = 0; i < 13; i++) rd(off[i], v[i]);
        chk_word(p1_high, {v[1], v[0]});
        // byte enables: a half written alone must leave the other half as it was
        wr(off[0], ~v[0], 2'h1);
        wr(off[1], ~v[1], 2'h2);
        rd(off[0], {v[0][15:8], ~v[0][7:0]});
        rd(off[1], {~v[1][15:8], v[1][7:0]});
        // pattern p: case 0 match, 1 disabled, 2 crc off by one bit
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 3; k++) begin
                m = {$random(seed), $random(seed)};
                m[0] = 1'b1;
                m[15] = 1'b1;
                m[16] = 1'b1;
                m[63] = 1'b1;
                for (int j = 0; j < 4 - p; j++) wr(off[4 + 6 * p + j], m[16 * j +: 16]);
                p3m3 = m[63:48];
                c = CRC_INIT;
                for (int i = 0; i < 70; i++) begin
                    wkup_rx_source_inst.fr[i] = 8'($random(seed));
                    if (i < 64 && m[i]) c = crc_step(c, wkup_rx_source_inst.fr[i]);
                end
                c = ~c ^ ((k == 2) ? 32'h00000001 : 32'h00000000);
                wr(off[2 + 6 * p], c[15:0]);
                wr(off[3 + 6 * p], c[31:16]);
                en2 = !(p == 0 && k == 1);
                en3 = !(p == 1 && k == 1);
                wk_q.push_back((k == 0) ? 2'(1 << p) : 2'h0);
                wkup_rx_source_inst.send(70, p == 1);
                repeat (3) @(posedge clock);
            end
        end
        repeat (4) @(posedge clock);
        miscompares += rd_q.size() + wk_q.size();
        test_done();
    end
endmodule
`default_nettype wire
